// ### hw/lbr_ramp_cfg.sv
// module: led bank ramp configuration registers, sink routing and per-bank ramp timers
// Behaviour
// (R1) Offset 0x00 reads silicon revision in bits 3:0, upper bits zero, read-only.
// (R2) Writing one to bit 0 at 0x01 starts a soft reset; bit self-clears.
// (R3) 0x10 bits 2:0 route high-voltage sinks 1-3 to bank A or B.
// (R4) 0x11 bits 1,2 put low-voltage sinks 2,3 on bank C or D/E.
// (R5) 0x11 bits 4,5 put low-voltage sinks 5,6 on bank F or G/H.
// (R6) Low-voltage sinks 1 and 4 are fixed to banks C and F.
// (R7) 0x12/0x13 hold 4-bit start-up and shutdown codes for banks A, B.
// (R8) Ramp codes map to durations from 2048 us up to 117.44 s.
// (R9) 0x14 to 0x19 hold 3-bit start-up and shutdown codes, banks C-H.
// (R10) 0x1A holds banks A/B run-time ramp up and down codes.
// (R11) 0x1B selects A/B run-time ramp: run-time, on/off times, or none.
// (R12) 0x1C and 0x1D hold run-time codes for groups C-E and F-H.
// (R13) 0x1F bits 3,2 disable dither for banks B and A.
// (R14) 0x1F bits 1,0 pick linear or exponential mapping, C-H and A/B.
// (R15) Soft reset returns every register here to its power-on default.
module lbr_ramp_cfg #(
  parameter logic [3:0]  SILICON_REV = 4'h1, // arbitrary value
  parameter int unsigned TICK_CYCLES = lbr_pkg::RAMP_STEP_CYC
) (
  input  wire logic                              SYS_CLK,
  input  wire logic                              RESETN,
  input  wire logic [7:0]                        ADDR,
  input  wire logic [7:0]                        WDATA,
  input  wire logic                              WR_EN,
  output logic      [7:0]                        RDATA,
  output logic                                   SOFT_RESET,
  input  wire logic [lbr_pkg::NUM_BANKS-1:0]     BANK_EN,
  input  wire logic [lbr_pkg::NUM_BANKS-1:0]     BRIGHT_UP,
  input  wire logic [lbr_pkg::NUM_BANKS-1:0]     BRIGHT_DOWN,
  output logic      [lbr_pkg::NUM_BANKS-1:0]     RAMP_BUSY,
  output logic      [lbr_pkg::NUM_BANKS-1:0]     RAMP_RISING,
  output logic      [8:0]                        HV_SINK_BANK,
  output logic      [17:0]                       LV_SINK_BANK,
  output logic      [1:0]                        DITHER_EN,
  output logic                                   LINEAR_MAP_AB,
  output logic                                   LINEAR_MAP_CH
);
  import lbr_pkg::*;

  typedef struct packed {
    logic                           sreset;
    logic [7:0]                     hv_route;
    logic [7:0]                     lv_route;
    logic [NUM_BANKS-1:0][7:0]      onoff;
    logic [7:0]                     rt_ab;
    logic [7:0]                     sel_ab;
    logic [7:0]                     rt_cde;
    logic [7:0]                     rt_fgh;
    logic [7:0]                     bright;
    logic [NUM_BANKS-1:0]           en_prev;
    logic [7:0]                     rdata;
    logic [TICK_W-1:0]              tick_cnt;
    logic                           tick;
  } lbr_cfg_s;

  localparam lbr_cfg_s CFG_RESET = '{
    hv_route: RST_HV_ROUTE,
    lv_route: RST_LV_ROUTE,
    default:  '0
  };

  lbr_cfg_s st;
  lbr_cfg_s next_st;

  logic [NUM_BANKS-1:0][3:0]       ramp_code;
  logic [NUM_BANKS-1:0]            ramp_start;
  logic [NUM_BANKS-1:0]            ramp_dir;
  logic [NUM_BANKS-1:0]            ramp_skip;
  logic [DUR_W-1:0]                lut_ticks [NUM_BANKS];
  logic [2:0]                      onoff_idx;

  assign onoff_idx = 3'(ADDR - OFS_ONOFF_BASE);

  // register file, soft reset and step prescaler
  always_comb begin
    next_st = st;
    next_st.en_prev = BANK_EN;
    if (st.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 1'b1;
      next_st.tick     = 1'b0;
    end
    // a write landing in the soft reset cycle is dropped so the defaults stick
    if (st.sreset) begin
      next_st.sreset   = 1'b0; // R2
      next_st.hv_route = RST_HV_ROUTE; // R15
      next_st.lv_route = RST_LV_ROUTE; // R15
      next_st.onoff    = '0; // R15
      next_st.rt_ab    = RST_ZERO; // R15
      next_st.sel_ab   = RST_ZERO; // R15
      next_st.rt_cde   = RST_ZERO; // R15
      next_st.rt_fgh   = RST_ZERO; // R15
      next_st.bright   = RST_ZERO; // R15
    end else if (WR_EN) begin
      if (ADDR == OFS_SRESET) begin
        next_st.sreset = WDATA[BIT_SRESET]; // R2
      end else if (ADDR == OFS_HV_ROUTE) begin
        next_st.hv_route = WDATA & MSK_HV_ROUTE; // R3
      end else if (ADDR == OFS_LV_ROUTE) begin
        next_st.lv_route = WDATA & MSK_LV_ROUTE; // R4 R5
      end else if (ADDR >= OFS_ONOFF_BASE && ADDR < OFS_ONOFF_C) begin
        next_st.onoff[onoff_idx] = WDATA & MSK_NIBBLE4; // R7
      end else if (ADDR >= OFS_ONOFF_C && ADDR <= OFS_ONOFF_LAST) begin
        next_st.onoff[onoff_idx] = WDATA & MSK_NIBBLE3; // R9
      end else if (ADDR == OFS_RT_AB) begin
        next_st.rt_ab = WDATA & MSK_NIBBLE4; // R10
      end else if (ADDR == OFS_SEL_AB) begin
        next_st.sel_ab = WDATA & MSK_SEL_AB; // R11
      end else if (ADDR == OFS_RT_CDE) begin
        next_st.rt_cde = WDATA & MSK_NIBBLE3; // R12
      end else if (ADDR == OFS_RT_FGH) begin
        next_st.rt_fgh = WDATA & MSK_NIBBLE3; // R12
      end else if (ADDR == OFS_BRIGHT) begin
        next_st.bright = WDATA & MSK_BRIGHT; // R13 R14
      end
    end
    // read data follows the address one cycle later; unmapped offsets read zero
    if (ADDR == OFS_REVISION) begin
      next_st.rdata = {4'h0, SILICON_REV}; // R1
    end else if (ADDR == OFS_SRESET) begin
      next_st.rdata = {7'h00, st.sreset};
    end else if (ADDR == OFS_HV_ROUTE) begin
      next_st.rdata = st.hv_route;
    end else if (ADDR == OFS_LV_ROUTE) begin
      next_st.rdata = st.lv_route;
    end else if (ADDR >= OFS_ONOFF_BASE && ADDR <= OFS_ONOFF_LAST) begin
      next_st.rdata = st.onoff[onoff_idx];
    end else if (ADDR == OFS_RT_AB) begin
      next_st.rdata = st.rt_ab;
    end else if (ADDR == OFS_SEL_AB) begin
      next_st.rdata = st.sel_ab;
    end else if (ADDR == OFS_RT_CDE) begin
      next_st.rdata = st.rt_cde;
    end else if (ADDR == OFS_RT_FGH) begin
      next_st.rdata = st.rt_fgh;
    end else if (ADDR == OFS_BRIGHT) begin
      next_st.rdata = st.bright;
    end else begin
      next_st.rdata = 8'h00;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      st <= CFG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ramp request: enable edges take the on/off codes, brightness steps the run-time codes (banks A/B: run-time, on/off or none per 0x1B)
  always_comb begin
    ramp_code  = '0;
    ramp_start = '0;
    ramp_dir   = '0;
    ramp_skip  = '0;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (BANK_EN[b] && !st.en_prev[b]) begin
        ramp_start[b] = 1'b1;
        ramp_dir[b]   = 1'b1;
        ramp_code[b]  = st.onoff[b][7:4]; // R7 R9
      end else if (!BANK_EN[b] && st.en_prev[b]) begin
        ramp_start[b] = 1'b1;
        ramp_code[b]  = st.onoff[b][3:0]; // R7 R9
      end else if (BRIGHT_UP[b] || BRIGHT_DOWN[b]) begin
        ramp_start[b] = 1'b1;
        ramp_dir[b]   = BRIGHT_UP[b];
        if (b < 2) begin
          if (st.sel_ab[2*b+1]) begin
            ramp_skip[b] = 1'b1; // R11
          end else if (st.sel_ab[2*b +: 2] == SEL_ONOFF) begin
            ramp_code[b] = BRIGHT_UP[b] ? st.onoff[b][7:4] : st.onoff[b][3:0]; // R11
          end else begin
            ramp_code[b] = BRIGHT_UP[b] ? st.rt_ab[7:4] : st.rt_ab[3:0]; // R10
          end
        end else if (b < 5) begin
          ramp_code[b] = BRIGHT_UP[b] ? st.rt_cde[7:4] : st.rt_cde[3:0]; // R12
        end else begin
          ramp_code[b] = BRIGHT_UP[b] ? st.rt_fgh[7:4] : st.rt_fgh[3:0]; // R12
        end
      end
    end
  end

  generate
    for (genvar g = 0; g < NUM_BANKS; g++) begin : g_bank
      lbr_ramp_if rif ();

      lbr_ramp_lut u_lut (
        .code  (ramp_code[g]),
        .ticks (lut_ticks[g])
      );

      assign rif.start = ramp_start[g];
      assign rif.clear = st.sreset;
      assign rif.rise  = ramp_dir[g];
      assign rif.ticks = ramp_skip[g] ? '0 : lut_ticks[g];
      assign rif.tick  = st.tick;

      lbr_ramp_timer u_timer (
        .clk    (SYS_CLK),
        .resetn (RESETN),
        .rif    (rif.timer)
      );

      assign RAMP_BUSY[g]   = rif.busy;
      assign RAMP_RISING[g] = rif.rising;
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      HV_SINK_BANK[3*i +: 3] = st.hv_route[i] ? BANK_B : BANK_A; // R3
    end
  end

  assign LV_SINK_BANK[2:0]   = BANK_C; // R6
  assign LV_SINK_BANK[5:3]   = st.lv_route[BIT_LV2] ? BANK_D : BANK_C; // R4
  assign LV_SINK_BANK[8:6]   = st.lv_route[BIT_LV3] ? BANK_E : BANK_C; // R4
  assign LV_SINK_BANK[11:9]  = BANK_F; // R6
  assign LV_SINK_BANK[14:12] = st.lv_route[BIT_LV5] ? BANK_G : BANK_F; // R5
  assign LV_SINK_BANK[17:15] = st.lv_route[BIT_LV6] ? BANK_H : BANK_F; // R5

  assign DITHER_EN[0]  = !st.bright[BIT_DITHER_A]; // R13
  assign DITHER_EN[1]  = !st.bright[BIT_DITHER_B]; // R13
  assign LINEAR_MAP_AB = st.bright[BIT_MAP_AB]; // R14
  assign LINEAR_MAP_CH = st.bright[BIT_MAP_CH]; // R14
  assign SOFT_RESET    = st.sreset;
  assign RDATA         = st.rdata;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);

  sequence s_write(logic [7:0] a, logic [7:0] d);
    WR_EN && !st.sreset && ADDR == a && WDATA == d;
  endsequence

  sequence s_read_after(logic [7:0] a);
    !WR_EN && !st.sreset && ADDR == a;
  endsequence

  a_rev_readback: assert property ( // R1
    (ADDR == OFS_REVISION) |=> RDATA == {4'h0, SILICON_REV})
    else $error("revision read returned wrong value");

  a_sreset_self_clear: assert property ( // R2
    s_write(OFS_SRESET, 8'h01) |=> SOFT_RESET ##1 !SOFT_RESET)
    else $error("soft reset bit did not pulse and clear");

  a_sreset_defaults: assert property ( // R15
    SOFT_RESET |=> HV_SINK_BANK == {BANK_B, BANK_B, BANK_A} && LV_SINK_BANK[5:3] == BANK_D
      && LV_SINK_BANK[17:15] == BANK_H && DITHER_EN == 2'b11 && !LINEAR_MAP_AB && RAMP_BUSY == '0)
    else $error("soft reset did not restore defaults");

  a_hv_route_b: assert property ( // R3
    s_write(OFS_HV_ROUTE, 8'h01) |=> HV_SINK_BANK == {BANK_A, BANK_A, BANK_B})
    else $error("high-voltage sink routing wrong");

  a_lv_route_c: assert property ( // R4
    s_write(OFS_LV_ROUTE, 8'h12) |=> LV_SINK_BANK[8:3] == {BANK_C, BANK_D}
      && LV_SINK_BANK[17:12] == {BANK_F, BANK_G})
    else $error("low-voltage sink routing wrong");

  a_lv_route_gh: assert property ( // R5
    s_write(OFS_LV_ROUTE, 8'h24) |=> LV_SINK_BANK[17:12] == {BANK_H, BANK_F}
      && LV_SINK_BANK[8:3] == {BANK_E, BANK_C})
    else $error("low-voltage sinks 5 and 6 routing wrong");

  a_fixed_sinks: assert property ( // R6
    LV_SINK_BANK[2:0] == BANK_C && LV_SINK_BANK[11:9] == BANK_F)
    else $error("fixed low-voltage sinks moved");

  a_startup_ramp: assert property ( // R7
    (BANK_EN[0] && !st.en_prev[0] && !st.sreset) |=> RAMP_BUSY[0] && RAMP_RISING[0])
    else $error("start-up ramp did not begin");

  a_code_scale: assert property ( // R8
    (ramp_code[2] == 4'h1) |-> lut_ticks[2] == 16'h0080)
    else $error("ramp code table wrong");

  a_ch_mask: assert property ( // R9
    s_write(OFS_ONOFF_LAST, 8'hFF) ##1 s_read_after(OFS_ONOFF_LAST) |=> RDATA == MSK_NIBBLE3)
    else $error("bank on/off register reserved bits not zero");

  a_no_ramp: assert property ( // R11
    (st.sel_ab[1] && (BRIGHT_UP[0] || BRIGHT_DOWN[0]) && BANK_EN[0] == st.en_prev[0] && !st.sreset)
      |=> !RAMP_BUSY[0])
    else $error("ramp ran while disabled");

  a_group_mask: assert property ( // R12
    s_write(OFS_RT_FGH, 8'hFF) ##1 s_read_after(OFS_RT_FGH) |=> RDATA == MSK_NIBBLE3)
    else $error("group run-time register reserved bits not zero");

  a_dither_off: assert property ( // R13
    s_write(OFS_BRIGHT, 8'h05) |=> DITHER_EN == 2'b10 && LINEAR_MAP_AB && !LINEAR_MAP_CH)
    else $error("dither disable wrong");

  a_linear_map: assert property ( // R14
    s_write(OFS_BRIGHT, 8'h0A) |=> LINEAR_MAP_CH && !LINEAR_MAP_AB && DITHER_EN == 2'b01)
    else $error("mapping mode wrong");

endmodule // lbr_ramp_cfg

// ### include/lbr_pkg.sv
// package: offsets, defaults, masks and ramp timing of the led bank ramp configuration block
package lbr_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned RAMP_STEP_NS  = 2048000;
  localparam int unsigned RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W        = 17;
  localparam int unsigned DUR_W         = 16;
  localparam int unsigned NUM_BANKS     = 8;

  localparam logic [7:0] OFS_REVISION   = 8'h00;
  localparam logic [7:0] OFS_SRESET     = 8'h01;
  localparam logic [7:0] OFS_HV_ROUTE   = 8'h10;
  localparam logic [7:0] OFS_LV_ROUTE   = 8'h11;
  localparam logic [7:0] OFS_ONOFF_BASE = 8'h12;
  localparam logic [7:0] OFS_ONOFF_C    = 8'h14;
  localparam logic [7:0] OFS_ONOFF_LAST = 8'h19;
  localparam logic [7:0] OFS_RT_AB      = 8'h1A;
  localparam logic [7:0] OFS_SEL_AB     = 8'h1B;
  localparam logic [7:0] OFS_RT_CDE     = 8'h1C;
  localparam logic [7:0] OFS_RT_FGH     = 8'h1D;
  localparam logic [7:0] OFS_BRIGHT     = 8'h1F;

  localparam logic [7:0] RST_HV_ROUTE   = 8'h06;
  localparam logic [7:0] RST_LV_ROUTE   = 8'h36;
  localparam logic [7:0] RST_ZERO       = 8'h00;

  localparam logic [7:0] MSK_HV_ROUTE   = 8'h07;
  localparam logic [7:0] MSK_LV_ROUTE   = 8'h36;
  localparam logic [7:0] MSK_NIBBLE4    = 8'hFF;
  localparam logic [7:0] MSK_NIBBLE3    = 8'h77;
  localparam logic [7:0] MSK_SEL_AB     = 8'h0F;
  localparam logic [7:0] MSK_BRIGHT     = 8'h0F;

  localparam int unsigned BIT_SRESET    = 0;
  localparam int unsigned BIT_LV2       = 1;
  localparam int unsigned BIT_LV3       = 2;
  localparam int unsigned BIT_LV5       = 4;
  localparam int unsigned BIT_LV6       = 5;
  localparam int unsigned BIT_MAP_AB    = 0;
  localparam int unsigned BIT_MAP_CH    = 1;
  localparam int unsigned BIT_DITHER_A  = 2;
  localparam int unsigned BIT_DITHER_B  = 3;

  localparam logic [1:0] SEL_RUNTIME    = 2'b00;
  localparam logic [1:0] SEL_ONOFF      = 2'b01;

  typedef enum logic [2:0] {
    BANK_A = 3'h0, BANK_B = 3'h1, BANK_C = 3'h2, BANK_D = 3'h3,
    BANK_E = 3'h4, BANK_F = 3'h5, BANK_G = 3'h6, BANK_H = 3'h7
  } lbr_bank_e;

  // ramp durations in steps of 2048 us, indexed by the 4-bit code
  localparam logic [DUR_W-1:0] RAMP_TICKS [16] = '{
    16'h0001, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h2000,
    16'h4000, 16'h5000, 16'h6000, 16'h7000, 16'h8000, 16'hA000, 16'hC000, 16'hE000
  };

endpackage

// ### include/lbr_ramp_if.sv
// interface: one bank's ramp request and ramp timer status
interface lbr_ramp_if;
  logic                      start;
  logic                      clear;
  logic                      rise;
  logic [lbr_pkg::DUR_W-1:0] ticks;
  logic                      tick;
  logic                      busy;
  logic                      rising;
  modport ctrl  (output start, clear, rise, ticks, tick, input busy, rising);
  modport timer (input start, clear, rise, ticks, tick, output busy, rising);
endinterface

// ### hw/lbr_ramp_lut.sv
// module: maps a 4-bit ramp code to a duration in 2048 us steps
module lbr_ramp_lut (
  input  wire logic [3:0]                code,
  output logic      [lbr_pkg::DUR_W-1:0] ticks
);
  import lbr_pkg::*;

  always_comb begin
    ticks = RAMP_TICKS[code]; // R8
  end

endmodule // lbr_ramp_lut

// ### hw/lbr_ramp_timer.sv
// module: one bank's ramp timer, counts down the loaded number of steps
module lbr_ramp_timer (
  input wire logic  clk,
  input wire logic  resetn,
  lbr_ramp_if.timer rif
);
  import lbr_pkg::*;

  typedef struct packed {
    logic [DUR_W-1:0] remain;
    logic             rising;
  } lbr_timer_s;

  lbr_timer_s st;
  lbr_timer_s next_st;

  // a new request reloads its full step count and restarts the ramp, an old one is dropped
  always_comb begin
    next_st = st;
    if (rif.clear) begin
      next_st = '0;
    end else if (rif.start) begin
      next_st.remain = rif.ticks;
      next_st.rising = rif.rise;
    end else if (rif.tick && st.remain != '0) begin
      next_st.remain = st.remain - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rif.busy   = (st.remain != '0);
  assign rif.rising = st.rising;

  a_timer_holds: assert property (@(posedge clk) disable iff (!resetn)
    (st.remain != '0 && !rif.tick && !rif.start && !rif.clear) |=> st.remain == $past(st.remain))
    else $error("ramp timer moved without a step tick");

endmodule // lbr_ramp_timer

// ### dv/lbr_ramp_cfg_tb.sv
// testbench: self-checking bench for the led bank ramp configuration block
module lbr_ramp_cfg_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lbr_pkg::*;

  localparam logic [3:0]  REV   = 4'h5; // arbitrary value
  localparam int unsigned TICKS = 8;    // short step keeps a 128-step ramp near 1000 cycles

  logic                 sys_clk;
  logic                 rst_n;
  logic [7:0]           addr;
  logic [7:0]           wdata;
  logic                 wr_en;
  logic [7:0]           rdata;
  logic                 soft_reset;
  logic [NUM_BANKS-1:0] bank_en;
  logic [NUM_BANKS-1:0] bright_up;
  logic [NUM_BANKS-1:0] bright_down;
  logic [NUM_BANKS-1:0] ramp_busy;
  logic [NUM_BANKS-1:0] ramp_rising;
  logic [8:0]           hv_bank;
  logic [17:0]          lv_bank;
  logic [1:0]           dither_en;
  logic                 lin_ab;
  logic                 lin_ch;
  int                   fail_count;
  int                   n_checks;

  // offset, default and writable mask; 0x1E and 0x20 are unmapped, 0x00 is read-only
  localparam logic [7:0] OFS [14] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D,
                                      8'h1F, 8'h1E, 8'h00, 8'h20};
  localparam logic [7:0] DFL [14] = '{8'h06, 8'h36, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                      8'h00, 8'h00, {4'h0, REV}, 8'h00};
  localparam logic [7:0] MSK [14] = '{8'h07, 8'h36, 8'hFF, 8'hFF, 8'h77, 8'h77, 8'hFF, 8'h0F, 8'h77, 8'h77,
                                      8'h0F, 8'h00, {4'h0, REV}, 8'h00};

  lbr_ramp_cfg #(
    .SILICON_REV (REV),
    .TICK_CYCLES (TICKS)
  ) u_dut (
    .SYS_CLK       (sys_clk),
    .RESETN        (rst_n),
    .ADDR          (addr),
    .WDATA         (wdata),
    .WR_EN         (wr_en),
    .RDATA         (rdata),
    .SOFT_RESET    (soft_reset),
    .BANK_EN       (bank_en),
    .BRIGHT_UP     (bright_up),
    .BRIGHT_DOWN   (bright_down),
    .RAMP_BUSY     (ramp_busy),
    .RAMP_RISING   (ramp_rising),
    .HV_SINK_BANK  (hv_bank),
    .LV_SINK_BANK  (lv_bank),
    .DITHER_EN     (dither_en),
    .LINEAR_MAP_AB (lin_ab),
    .LINEAR_MAP_CH (lin_ch)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #2;
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge sys_clk);
    #2;
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #2;
    addr = a;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #2;
    d = rdata;
  endtask

  task automatic pulse(input logic up, input int b);
    @(posedge sys_clk);
    #2;
    if (up) bright_up[b] = 1'b1;
    else bright_down[b] = 1'b1;
    @(posedge sys_clk);
    #2;
    bright_up   = '0;
    bright_down = '0;
  endtask

  // a wait that runs out of cycles is a failure in itself
  task automatic wait_busy(input int b, input logic lvl, input int lim);
    int n;
    n = 0;
    while (ramp_busy[b] !== lvl && n < lim) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    if (ramp_busy[b] !== lvl) begin
      fail_count++;
      $display("wrong value at %0t: ramp busy of bank %0d never reached %b", $time, b, lvl);
      conclude();
    end
  endtask

  task automatic t_defaults;
    logic [7:0] d;
    check(hv_bank, 9'b001001000, "hv routing default");
    check(lv_bank, {3'd7, 3'd6, 3'd5, 3'd4, 3'd3, 3'd2}, "lv routing default");
    check({dither_en, lin_ab, lin_ch}, 4'b1100, "brightness default");
    for (int i = 0; i < 14; i++) begin
      rd(OFS[i], d);
      check(d, DFL[i], "register default");
    end
    rd(OFS_SRESET, d);
    check(d, 8'h00, "soft reset bit idle");
  endtask

  task automatic t_masks;
    logic [7:0] d;
    for (int i = 0; i < 14; i++) begin
      wr(OFS[i], 8'hFF);
      rd(OFS[i], d);
      check(d, MSK[i], "write all ones");
    end
    check(hv_bank, 9'b001001001, "hv all on bank b");
    check({dither_en, lin_ab, lin_ch}, 4'b0011, "dither off, linear");
  endtask

  task automatic t_route;
    wr(OFS_HV_ROUTE, 8'h01);
    check(hv_bank, 9'b000000001, "hv sink1 b, others a");
    wr(OFS_LV_ROUTE, 8'h12);
    check(lv_bank, {3'd5, 3'd6, 3'd5, 3'd2, 3'd3, 3'd2}, "lv sink2 d, sink5 g");
    wr(OFS_LV_ROUTE, 8'h24);
    check(lv_bank, {3'd7, 3'd5, 3'd5, 3'd4, 3'd2, 3'd2}, "lv sink3 e, sink6 h");
    wr(OFS_BRIGHT, 8'h05);
    check({dither_en, lin_ab, lin_ch}, 4'b1010, "a dither off, ab linear");
    wr(OFS_BRIGHT, 8'h0A);
    check({dither_en, lin_ab, lin_ch}, 4'b0101, "b dither off, ch linear");
  endtask

  task automatic t_soft;
    wr(OFS_SRESET, 8'h01);
    check(soft_reset, 1'b1, "soft reset pulse");
    @(posedge sys_clk);
    #2;
    check(soft_reset, 1'b0, "soft reset self clears");
    @(posedge sys_clk);
    #2;
    t_defaults();
  endtask

  task automatic t_ramp;
    wr(OFS_ONOFF_C, 8'h10);
    @(posedge sys_clk);
    #2;
    bank_en[0] = 1'b1;
    bank_en[2] = 1'b1;
    @(posedge sys_clk);
    #2;
    check({ramp_busy[2], ramp_rising[2]}, 2'b11, "bank c start-up ramp");
    check({ramp_busy[0], ramp_rising[0]}, 2'b11, "bank a start-up ramp");
    // code 1 is 128 steps, so the ramp cannot end before 127 steps have passed
    repeat (1000) @(posedge sys_clk);
    #2;
    check(ramp_busy[2], 1'b1, "bank c ramp still running");
    wait_busy(2, 1'b0, 40);
    bank_en[2] = 1'b0;
    @(posedge sys_clk);
    #2;
    check({ramp_busy[2], ramp_rising[2]}, 2'b10, "bank c shutdown ramp");
    wait_busy(2, 1'b0, 12);
    pulse(1'b1, 0);
    check({ramp_busy[0], ramp_rising[0]}, 2'b11, "bank a run-time up");
    wait_busy(0, 1'b0, 12);
    wr(OFS_SEL_AB, 8'h02);
    pulse(1'b0, 0);
    check(ramp_busy[0], 1'b0, "bank a ramp disabled");
    wr(OFS_RT_FGH, 8'h10);
    pulse(1'b1, 5);
    check({ramp_busy[5], ramp_rising[5]}, 2'b11, "bank f run-time up");
    wr(OFS_SEL_AB, 8'h01);
    wr(OFS_ONOFF_BASE, 8'h01);
    pulse(1'b0, 0);
    check({ramp_busy[0], ramp_rising[0]}, 2'b10, "bank a uses shutdown time");
    repeat (100) @(posedge sys_clk);
    #2;
    check(ramp_busy[0], 1'b1, "bank a long shutdown time");
    check(ramp_busy[5], 1'b1, "bank f long run-time up");
    wr(OFS_SRESET, 8'h01);
    @(posedge sys_clk);
    #2;
    check(ramp_busy[0], 1'b0, "soft reset stops timer");
    check(ramp_busy, 8'h00, "soft reset stops all timers");
  endtask

  initial begin
    sys_clk     = 1'b0;
    rst_n       = 1'b0;
    addr        = 8'h00;
    wdata       = 8'h00;
    wr_en       = 1'b0;
    bank_en     = '0;
    bright_up   = '0;
    bright_down = '0;
    fail_count  = 0;
    n_checks    = 0;
    repeat (5) @(posedge sys_clk);
    #2;
    rst_n = 1'b1;
    t_defaults();
    t_masks();
    t_route();
    t_soft();
    t_ramp();
    conclude();
  end

endmodule // lbr_ramp_cfg_tb
